//--- logic/mtv_pkg.sv
// Shared constants, types and helpers of the multi-transfer and vector-table unit
`default_nettype none
package mtv_pkg;

  // ****************************************************************
  // Execution state word layout
  // ****************************************************************
  localparam int ESW_T_BIT   = 24;
  localparam int CF_HI_MSB   = 26;
  localparam int CF_HI_LSB   = 25;
  localparam int CF_MID_MSB  = 15;
  localparam int CF_MID_LSB  = 12;
  localparam int CF_LO_MSB   = 11;
  localparam int CF_LO_LSB   = 10;
  localparam logic [31:0] ESW_RST = 32'h0000_0000;
  localparam logic [1:0]  CF_PAD  = 2'h0;
  localparam logic [3:0]  REG_NONE = 4'h0;
  localparam logic [3:0]  PC_REG   = 4'hF;

  // ****************************************************************
  // Register map (byte offsets on APB)
  // ****************************************************************
  localparam logic [11:0] REG_TBL_S  = 12'h000;
  localparam logic [11:0] REG_TBL_NS = 12'h004;
  localparam logic [11:0] REG_STAT   = 12'h008;
  localparam logic [11:0] REG_ESW    = 12'h00C;
  localparam logic [31:0] TBL_MASK   = 32'hFFFF_FF80;
  localparam logic [31:0] TBL_RST    = 32'h0000_0000;
  localparam int          STAT_INV   = 0;
  localparam int          STAT_RES   = 1;

  // ****************************************************************
  // Vector fetch
  // ****************************************************************
  localparam int             VEC_NUM_W = 9;
  localparam int             VEC_SH    = 2;
  localparam logic [8:0]     MSP_VEC   = 9'h000;

  // Multi-transfer kind: bit0 descending, bit1 store, bit2 floating point
  typedef enum logic [2:0] {
    MT_LD_ASC     = 3'b000,
    MT_LD_DESC    = 3'b001,
    MT_ST_ASC     = 3'b010,
    MT_ST_DESC    = 3'b011,
    MT_FP_LD_ASC  = 3'b100,
    MT_FP_LD_DESC = 3'b101,
    MT_FP_ST_ASC  = 3'b110,
    MT_FP_ST_DESC = 3'b111
  } mtv_kind_t;
  localparam int KIND_DESC = 0;
  localparam int KIND_ST   = 1;
  localparam int KIND_FP   = 2;

  typedef enum logic {
    FT_IDLE = 1'b0,
    FT_WAIT = 1'b1
  } mtv_ft_state_t;

  function automatic logic [7:0] cf_get(input logic [31:0] w);
    cf_get = {w[CF_HI_MSB:CF_HI_LSB], w[CF_MID_MSB:CF_MID_LSB], w[CF_LO_MSB:CF_LO_LSB]};
  endfunction : cf_get

endpackage : mtv_pkg
`default_nettype wire

//--- logic/mtv_vec_fetch.sv
// Vector table entry fetch: table select, address generation, word read
`timescale 1ns/1ns
`default_nettype none
module mtv_vec_fetch #(
  parameter bit HAS_SEC = 1'b1
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          vec_req,
  input  wire logic [mtv_pkg::VEC_NUM_W-1:0] vec_num,
  input  wire logic                          vec_secure,
  input  wire logic [31:0]                   base_s,
  input  wire logic [31:0]                   base_ns,
  output logic                               vec_busy,
  output logic                               mem_req,
  output logic [31:0]                        mem_addr,
  input  wire logic                          mem_ack,
  input  wire logic [31:0]                   mem_rdata,
  output logic                               vec_done,
  output logic [31:0]                        vec_data,
  output logic                               vec_bad
);

  mtv_pkg::mtv_ft_state_t      st_r;
  logic [mtv_pkg::VEC_NUM_W-1:0] num_r;
  logic [31:0]                 base_sel;

  // Without the security extension only the single table register exists
  assign base_sel = (HAS_SEC && !vec_secure) ? base_ns : base_s;
  assign vec_busy = (st_r == mtv_pkg::FT_WAIT);

  // ****************************************************************
  // Request sequencing
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r     <= mtv_pkg::FT_IDLE;
      mem_req  <= 1'b0;
      mem_addr <= 32'h0000_0000;
      num_r    <= '0;
    end else begin
      unique case (st_r)
        mtv_pkg::FT_IDLE: begin
          if (vec_req) begin
            st_r     <= mtv_pkg::FT_WAIT;
            mem_req  <= 1'b1;
            num_r    <= vec_num;
            mem_addr <= base_sel + {21'h00_0000, vec_num, 2'h0};
          end
        end
        mtv_pkg::FT_WAIT: begin
          if (mem_ack) begin
            st_r    <= mtv_pkg::FT_IDLE;
            mem_req <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Result capture
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      vec_done <= 1'b0;
      vec_data <= 32'h0000_0000;
      vec_bad  <= 1'b0;
    end else begin
      vec_done <= vec_busy && mem_ack;
      if (vec_busy && mem_ack) begin
        vec_data <= mem_rdata;
        vec_bad  <= (num_r != mtv_pkg::MSP_VEC) && !mem_rdata[0];
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_issue;
    !vec_busy && vec_req;
  endsequence

  sequence s_ack;
    vec_busy && mem_ack;
  endsequence

  AST_VEC_REQ: assert property (s_issue |=> mem_req && vec_busy)
    else $error("vector read not issued after request");
  AST_VEC_ADDR: assert property (s_issue |=>
    (mem_addr == $past(base_sel) + {21'h00_0000, $past(vec_num), 2'h0}))
    else $error("vector address not base plus four times number");
  AST_VEC_DONE: assert property (s_ack |=> vec_done && !vec_busy && vec_data == $past(mem_rdata))
    else $error("vector word not returned after ack");
  AST_VEC_BAD: assert property (vec_done && num_r != mtv_pkg::MSP_VEC |-> vec_bad == !vec_data[0])
    else $error("handler entry bit zero check wrong");

endmodule : mtv_vec_fetch
`default_nettype wire

//--- logic/mtv_exc_unit.sv
// Multi-transfer interruption handling, execution state word and vector tables
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Resume exists only with main extension
// - Restart from beginning always possible
// - Only listed multi-transfer forms may resume
// - Continuation field split, pads zero, middle register
// - Integer resume names next register to transfer
// - Floating resume names lowest unfinished doubleword
// - Non-zero field on other instruction faults
// - Resumed load leaves unfinished list registers unknown
// - Already loaded program counter restored before entry
// - No main extension: restart, base restored
// - Async outside conditional block uses resume
// - Stack base: descending final, ascending initial
// - Other base: final value written on resume
// - Otherwise restart, restore base, zero field unless in conditional block
// - Load including base restores base, restarts once base already loaded
// - Secure and non-secure tables, both configurable
// - Single table base writable or reads zero
// - Word zero stack pointer, word N handler
// - Handler entry bit zero clear faults
// - Entry bit zero copied to instruction-set flag
module mtv_exc_unit #(
  parameter bit HAS_MAIN = 1'b1,
  parameter bit HAS_SEC  = 1'b1,
  parameter bit HAS_FP   = 1'b1,
  parameter bit TBL_CFG  = 1'b1
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Exception taken during a multi-transfer
  input  wire logic                          exc_take,
  input  wire logic                          exc_async,
  input  wire logic                          in_cond_block,
  input  wire mtv_pkg::mtv_kind_t            mt_kind,
  input  wire logic                          mt_base_is_sp,
  input  wire logic [31:0]                   base_orig,
  input  wire logic [31:0]                   base_final,
  input  wire logic [3:0]                    next_reg,
  input  wire logic [3:0]                    fp_next_dreg,
  input  wire logic [15:0]                   list_mask,
  input  wire logic                          list_has_base,
  input  wire logic                          base_loaded,
  input  wire logic                          pc_loaded,
  input  wire logic [31:0]                   pc_orig,
  output logic                               dec_valid,
  output logic                               dec_resume,
  output logic [31:0]                        base_out,
  output logic                               pc_restore,
  output logic [31:0]                        pc_out,
  output logic [15:0]                        unk_mask,
  // Execution state word restore and instruction issue
  input  wire logic                          esw_load,
  input  wire logic [31:0]                   esw_in,
  output logic [31:0]                        execution_state_word,
  input  wire logic                          instr_valid,
  input  wire logic                          instr_is_multi,
  output logic                               misuse_fault,
  output logic                               invalid_state_cause,
  // Vector fetch
  input  wire logic                          ent_req,
  input  wire logic [mtv_pkg::VEC_NUM_W-1:0] ent_num,
  input  wire logic                          ent_secure,
  output logic                               ent_busy,
  output logic                               mem_req,
  output logic [31:0]                        mem_addr,
  input  wire logic                          mem_ack,
  input  wire logic [31:0]                   mem_rdata,
  output logic                               ent_done,
  output logic [31:0]                        ent_value
);

  logic [31:0] esw_r;
  logic [31:0] esw_nxt;
  logic [31:0] tbl_s_r;
  logic [31:0] tbl_ns_r;
  logic        inv_r;
  logic        vdone;
  logic [31:0] vdata;
  logic        vbad;
  logic        msp_fetch_r;
  logic        bad_pend_r;
  logic [7:0]  cf_cur;
  logic        cf_nz;
  logic        is_load;
  logic        is_fp;
  logic        kind_ok;
  logic        base_in_ld;
  logic        res_ok;
  logic [7:0]  cf_new;
  logic [31:0] base_nxt;
  logic        wr_acc;
  logic        rd_set;
  logic        hit;
  logic        hit_ns;

  // ****************************************************************
  // Resume or restart decision
  // ****************************************************************
  assign is_load    = !mt_kind[mtv_pkg::KIND_ST];
  assign is_fp      = mt_kind[mtv_pkg::KIND_FP];
  assign kind_ok    = !is_fp || HAS_FP;
  assign base_in_ld = is_load && list_has_base;
  // A load that has already overwritten its base cannot be resumed safely, so it restarts
  assign res_ok = HAS_MAIN && exc_async && !in_cond_block && kind_ok
                  && !(base_in_ld && base_loaded);
  assign cf_new = {mtv_pkg::CF_PAD, (is_fp ? fp_next_dreg : next_reg), mtv_pkg::CF_PAD};

  always_comb begin
    base_nxt = base_orig;
    if (res_ok && !base_in_ld) begin
      if (mt_base_is_sp) begin
        base_nxt = mt_kind[mtv_pkg::KIND_DESC] ? base_final : base_orig;
      end else begin
        base_nxt = base_final;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dec_valid  <= 1'b0;
      dec_resume <= 1'b0;
      base_out   <= 32'h0000_0000;
      pc_restore <= 1'b0;
      pc_out     <= 32'h0000_0000;
    end else begin
      dec_valid <= exc_take;
      if (exc_take) begin
        dec_resume <= res_ok;
        base_out   <= base_nxt;
        pc_restore <= is_load && !is_fp && list_mask[mtv_pkg::PC_REG] && pc_loaded;
        pc_out     <= pc_orig;
      end
    end
  end

  // Registers at or past the resume point, other than PC, are unknown after a resumed integer load
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_unk
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          unk_mask[gi] <= 1'b0;
        end else if (exc_take) begin
          unk_mask[gi] <= res_ok && is_load && !is_fp && list_mask[gi]
                          && (4'(gi) >= next_reg) && (4'(gi) != mtv_pkg::PC_REG)
                          && !(list_has_base && base_loaded);
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Execution state word
  // ****************************************************************
  assign cf_cur = mtv_pkg::cf_get(esw_r);
  assign cf_nz  = (cf_cur[7:6] == mtv_pkg::CF_PAD) && (cf_cur[1:0] == mtv_pkg::CF_PAD)
                  && (cf_cur[5:2] != mtv_pkg::REG_NONE);

  always_comb begin
    esw_nxt = esw_r;
    if (esw_load) begin
      esw_nxt = esw_in;
    end
    if (exc_take && (res_ok || !in_cond_block)) begin
      // Inside a conditional block these bits carry block state and are left alone
      esw_nxt[mtv_pkg::CF_HI_MSB:mtv_pkg::CF_HI_LSB]   = res_ok ? cf_new[7:6] : mtv_pkg::CF_PAD;
      esw_nxt[mtv_pkg::CF_MID_MSB:mtv_pkg::CF_MID_LSB] = res_ok ? cf_new[5:2] : mtv_pkg::REG_NONE;
      esw_nxt[mtv_pkg::CF_LO_MSB:mtv_pkg::CF_LO_LSB]   = res_ok ? cf_new[1:0] : mtv_pkg::CF_PAD;
    end
    if (vdone && !msp_fetch_r) begin
      esw_nxt[mtv_pkg::ESW_T_BIT] = vdata[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      esw_r <= mtv_pkg::ESW_RST;
    end else begin
      esw_r <= esw_nxt;
    end
  end
  assign execution_state_word = esw_r;

  // ****************************************************************
  // Invalid-state faults
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bad_pend_r   <= 1'b0;
      misuse_fault <= 1'b0;
    end else begin
      misuse_fault <= instr_valid && ((!instr_is_multi && cf_nz) || bad_pend_r);
      if (vdone && !msp_fetch_r) begin
        bad_pend_r <= vbad;
      end else if (instr_valid) begin
        bad_pend_r <= 1'b0;
      end
    end
  end
  assign invalid_state_cause = misuse_fault;

  // ****************************************************************
  // Vector fetch
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      msp_fetch_r <= 1'b0;
    end else if (ent_req && !ent_busy) begin
      msp_fetch_r <= (ent_num == mtv_pkg::MSP_VEC);
    end
  end

  mtv_vec_fetch #(
    .HAS_SEC (HAS_SEC)
  ) u_fetch (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .vec_req    (ent_req),
    .vec_num    (ent_num),
    .vec_secure (ent_secure),
    .base_s     (tbl_s_r),
    .base_ns    (tbl_ns_r),
    .vec_busy   (ent_busy),
    .mem_req    (mem_req),
    .mem_addr   (mem_addr),
    .mem_ack    (mem_ack),
    .mem_rdata  (mem_rdata),
    .vec_done   (vdone),
    .vec_data   (vdata),
    .vec_bad    (vbad)
  );
  assign ent_done  = vdone;
  assign ent_value = vdata;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_set = psel && !penable;
  assign hit_ns = HAS_SEC && (paddr == mtv_pkg::REG_TBL_NS);
  assign hit    = (paddr == mtv_pkg::REG_TBL_S) || hit_ns
                  || (paddr == mtv_pkg::REG_STAT) || (paddr == mtv_pkg::REG_ESW);
  assign pslverr = psel && penable && !hit;

  // Low bits stay zero: tables are at least 128-byte aligned
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tbl_s_r  <= mtv_pkg::TBL_RST;
      tbl_ns_r <= mtv_pkg::TBL_RST;
    end else if (wr_acc && TBL_CFG) begin
      if (paddr == mtv_pkg::REG_TBL_S) begin
        tbl_s_r <= pwdata & mtv_pkg::TBL_MASK;
      end
      if (hit_ns) begin
        tbl_ns_r <= pwdata & mtv_pkg::TBL_MASK;
      end
    end
  end

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      inv_r <= 1'b0;
    end else if (misuse_fault) begin
      inv_r <= 1'b1;
    end else if (wr_acc && paddr == mtv_pkg::REG_STAT && pwdata[mtv_pkg::STAT_INV]) begin
      inv_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_set) begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        mtv_pkg::REG_TBL_S:  prdata <= tbl_s_r;
        mtv_pkg::REG_TBL_NS: prdata <= HAS_SEC ? tbl_ns_r : 32'h0000_0000;
        mtv_pkg::REG_STAT: begin
          prdata[mtv_pkg::STAT_INV] <= inv_r;
          prdata[mtv_pkg::STAT_RES] <= dec_resume;
        end
        mtv_pkg::REG_ESW:    prdata <= esw_r;
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_take_resume;
    exc_take && res_ok;
  endsequence

  AST_DEC_FOLLOWS: assert property (exc_take |=> dec_valid)
    else $error("decision not produced after exception");
  AST_NO_MAIN_RESTART: assert property (exc_take && (!HAS_MAIN || in_cond_block || !exc_async) |=> !dec_resume)
    else $error("resume chosen where restart is required");
  AST_RESTART_BASE: assert property (dec_valid && !dec_resume |-> base_out == $past(base_orig))
    else $error("restart did not restore base");
  AST_SP_ASC: assert property (s_take_resume ##0 (mt_base_is_sp && !mt_kind[mtv_pkg::KIND_DESC] && !base_in_ld)
    |=> base_out == $past(base_orig))
    else $error("ascending stack base not initial");
  AST_PLAIN_FINAL: assert property (s_take_resume ##0 (!mt_base_is_sp && !base_in_ld)
    |=> base_out == $past(base_final))
    else $error("base not set to final value");
  AST_CF_FORMAT: assert property (s_take_resume ##0 !esw_load |=> cf_cur == $past(cf_new) && cf_cur[1:0] == 2'h0)
    else $error("continuation field malformed");
  AST_CF_CLEAR: assert property (exc_take && !res_ok && !in_cond_block && !esw_load |=> cf_cur == 8'h00)
    else $error("continuation field not cleared on restart");
  AST_PC_BACK: assert property (exc_take && is_load && !is_fp && list_mask[mtv_pkg::PC_REG] && pc_loaded
    |=> pc_restore && pc_out == $past(pc_orig))
    else $error("loaded pc not restored");
  AST_STRAY_CF: assert property (instr_valid && !instr_is_multi && cf_nz |=> misuse_fault)
    else $error("no fault for stray continuation field");
  AST_T_COPY: assert property (vdone && !msp_fetch_r && !exc_take |=> esw_r[mtv_pkg::ESW_T_BIT] == $past(vdata[0]))
    else $error("instruction-set flag not copied");
  AST_RAZ: assert property (!TBL_CFG |-> tbl_s_r == 32'h0000_0000 && tbl_ns_r == 32'h0000_0000)
    else $error("read-zero table base changed");

endmodule : mtv_exc_unit
`default_nettype wire

//--- tb/mtv_exc_unit_tb.sv
// Self-checking bench of the multi-transfer and vector-table unit
`timescale 1ns/1ns
`default_nettype none
module mtv_exc_unit_tb;
  logic               clk_sys, rst, psel, penable, pwrite, prdy, pready, pslverr, err;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd, base_orig, base_final, pc_orig, base_out, pc_out;
  logic [31:0]        esw_in, execution_state_word, mem_addr, mem_rdata, ent_value;
  logic               exc_take, exc_async, in_cond_block, mt_base_is_sp, list_has_base, base_loaded, pc_loaded;
  logic               dec_valid, dec_resume, pc_restore, esw_load, instr_valid, instr_is_multi;
  logic               misuse_fault, invalid_state_cause, ent_req, ent_secure, ent_busy, mem_req, mem_ack, ent_done;
  logic [3:0]         next_reg, fp_next_dreg;
  logic [15:0]        list_mask, unk_mask;
  logic [8:0]         ent_num;
  mtv_pkg::mtv_kind_t mt_kind;
  int                 failures, compares, cycles;

  mtv_exc_unit u_dut (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .exc_take, .exc_async, .in_cond_block, .mt_kind, .mt_base_is_sp, .base_orig, .base_final,
    .next_reg, .fp_next_dreg, .list_mask, .list_has_base, .base_loaded, .pc_loaded, .pc_orig,
    .dec_valid, .dec_resume, .base_out, .pc_restore, .pc_out, .unk_mask, .esw_load, .esw_in,
    .execution_state_word, .instr_valid, .instr_is_multi, .misuse_fault, .invalid_state_cause,
    .ent_req, .ent_num, .ent_secure, .ent_busy, .mem_req, .mem_addr, .mem_ack, .mem_rdata,
    .ent_done, .ent_value
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict

  // Request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic exc(input logic as, input logic cb, input logic sp, input mtv_pkg::mtv_kind_t k,
                     input logic ex_res, input logic [31:0] ex_base);
    @(posedge clk_sys);
    exc_take <= 1'b1;
    exc_async <= as;
    in_cond_block <= cb;
    mt_base_is_sp <= sp;
    mt_kind <= k;
    @(posedge clk_sys);
    exc_take <= 1'b0;
    #1;
    check("dec_valid", dec_valid, 1'b1);
    check("dec_resume", dec_resume, ex_res);
    check("base_out", base_out, ex_base);
  endtask : exc

  task automatic instr(input logic multi, input logic exp);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_is_multi <= multi;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    check("misuse_fault", misuse_fault, exp);
    check("invalid_state_cause", invalid_state_cause, exp);
  endtask : instr

  // Software restore of the state word, as on unstacking
  task automatic esw_restore(input logic [31:0] w);
    @(posedge clk_sys);
    esw_load <= 1'b1;
    esw_in <= w;
    @(posedge clk_sys);
    esw_load <= 1'b0;
    #1;
    check("esw restore", execution_state_word, w);
  endtask : esw_restore

  task automatic fetch(input logic [8:0] num, input logic sec, input logic [31:0] word, input logic [31:0] ex_a);
    @(posedge clk_sys);
    ent_req <= 1'b1;
    ent_num <= num;
    ent_secure <= sec;
    @(posedge clk_sys);
    ent_req <= 1'b0;
    #1;
    while (mem_req !== 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    check("mem_addr", mem_addr, ex_a);
    check("ent_busy", ent_busy, 1'b1);
    @(posedge clk_sys);
    mem_ack <= 1'b1;
    mem_rdata <= word;
    @(posedge clk_sys);
    mem_ack <= 1'b0;
    mem_rdata <= ~word;
    #1;
    check("ent_done", ent_done, 1'b1);
    check("ent_value", ent_value, word);
    @(posedge clk_sys);
    #1;
  endtask : fetch

  // ****************************************************************
  // Clock, timeout and scenarios
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    {psel, penable, pwrite, exc_take, exc_async, in_cond_block, mt_base_is_sp} = '0;
    {list_has_base, base_loaded, pc_loaded, esw_load, instr_valid, instr_is_multi, ent_req} = '0;
    {ent_secure, mem_ack, paddr, pwdata, next_reg, list_mask, ent_num, mem_rdata, esw_in} = '0;
    mt_kind = mtv_pkg::MT_LD_ASC;
    base_orig = 32'h0000_1000;
    base_final = 32'h0000_1020;
    pc_orig = 32'h0000_0400;
    fp_next_dreg = 4'h9;
    rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, mtv_pkg::REG_ESW, 32'h0);
    check("esw reset", rd, mtv_pkg::ESW_RST);
    apb(1'b1, mtv_pkg::REG_TBL_S, 32'hFFFF_FFFF);
    apb(1'b0, mtv_pkg::REG_TBL_S, 32'h0);
    check("secure base", rd, mtv_pkg::TBL_MASK);
    apb(1'b1, mtv_pkg::REG_TBL_S, 32'h0000_0100);
    apb(1'b1, mtv_pkg::REG_TBL_NS, 32'h0000_0200);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped error", err, 1'b1);
    next_reg <= 4'h5;
    exc(1'b1, 1'b0, 1'b0, mtv_pkg::MT_LD_DESC, 1'b1, 32'h0000_1020);
    check("cont field", mtv_pkg::cf_get(execution_state_word), 32'h14);
    instr(1'b0, 1'b1);
    instr(1'b1, 1'b0);
    exc(1'b1, 1'b0, 1'b0, mtv_pkg::MT_FP_ST_ASC, 1'b1, 32'h0000_1020);
    check("fp cont field", execution_state_word[15:12], 4'h9);
    exc(1'b1, 1'b0, 1'b1, mtv_pkg::MT_ST_DESC, 1'b1, 32'h0000_1020);
    exc(1'b1, 1'b0, 1'b1, mtv_pkg::MT_LD_ASC, 1'b1, 32'h0000_1000);
    exc(1'b1, 1'b1, 1'b0, mtv_pkg::MT_ST_ASC, 1'b0, 32'h0000_1000);
    check("cond block field", execution_state_word[15:12], 4'h5);
    exc(1'b0, 1'b0, 1'b0, mtv_pkg::MT_LD_ASC, 1'b0, 32'h0000_1000);
    check("restart field", mtv_pkg::cf_get(execution_state_word), 32'h0);
    list_has_base <= 1'b1;
    base_loaded <= 1'b1;
    exc(1'b1, 1'b0, 1'b0, mtv_pkg::MT_LD_ASC, 1'b0, 32'h0000_1000);
    list_has_base <= 1'b0;
    list_mask <= 16'h8030;
    pc_loaded <= 1'b1;
    exc(1'b1, 1'b0, 1'b0, mtv_pkg::MT_LD_ASC, 1'b1, 32'h0000_1020);
    check("pc_restore", pc_restore, 1'b1);
    check("pc_out", pc_out, 32'h0000_0400);
    check("unk_mask", unk_mask, 32'h0000_0020);
    fetch(9'h003, 1'b1, 32'h0000_2001, 32'h0000_010C);
    check("flag set", execution_state_word[mtv_pkg::ESW_T_BIT], 1'b1);
    fetch(9'h005, 1'b0, 32'h0000_3000, 32'h0000_0214);
    check("flag clear", execution_state_word[mtv_pkg::ESW_T_BIT], 1'b0);
    instr(1'b1, 1'b1);
    apb(1'b0, mtv_pkg::REG_STAT, 32'h0);
    check("status", rd, 32'h0000_0003);
    apb(1'b1, mtv_pkg::REG_STAT, 32'h0000_0001);
    apb(1'b0, mtv_pkg::REG_STAT, 32'h0);
    check("status clear", rd, 32'h0000_0002);
    fetch(9'h000, 1'b1, 32'h2000_0800, 32'h0000_0100);
    esw_restore(32'h0100_5000);
    instr(1'b0, 1'b1);
    esw_restore(32'h0100_0000);
    instr(1'b0, 1'b0);
    print_verdict();
  end
endmodule : mtv_exc_unit_tb
`default_nettype wire
